/* shared/spl_pkg.sv */
// constants and types for the sensor port parameter logic
package spl_pkg;
  localparam logic [11:0] ADDR_PORT_CFG  = 12'h000;
  localparam logic [11:0] ADDR_MAKER     = 12'h004;
  localparam logic [11:0] ADDR_PART      = 12'h008;
  localparam logic [11:0] ADDR_PERIOD    = 12'h00c;
  localparam logic [11:0] ADDR_STATUS    = 12'h010;
  localparam logic [11:0] ADDR_DEV_ID    = 12'h014;
  localparam logic [11:0] ADDR_DEV_MIN   = 12'h018;
  localparam logic [11:0] ADDR_BACKUP    = 12'h01c;
  localparam logic [11:0] ADDR_OUT_LO    = 12'h020;
  localparam logic [11:0] ADDR_OUT_HI    = 12'h024;
  localparam logic [11:0] ADDR_IN_LO     = 12'h028;
  localparam logic [11:0] ADDR_IN_HI     = 12'h02c;
  localparam logic [11:0] ADDR_CTRL      = 12'h030;
  // port_cfg fields
  localparam int PM_LSB    = 0;
  localparam int VAL_LSB   = 4;
  localparam int SWAP_LSB  = 8;
  localparam int FAIL_LSB  = 12;
  localparam int SUP_BIT   = 16;
  localparam int MAP_LSB   = 20;
  localparam int PDLEN_LSB = 24;
  // reset values
  localparam logic [15:0] MAKER_RST  = 16'h0001;
  localparam logic [23:0] PART_RST   = 24'h000001;
  localparam logic [7:0]  PERIOD_RST = 8'h00;
  localparam logic [3:0]  LEN_RST    = 4'h8;
  // cycle time in 0.1 ms units
  localparam logic [11:0] BASE1_OFS  = 12'h040;
  localparam logic [11:0] BASE2_OFS  = 12'h140;
  localparam logic [11:0] MAX_TENTHS = 12'h530;
  localparam logic [11:0] MIN_TENTHS = 12'h004;
  localparam int          TENTH_NS   = 100000;
  localparam int          CLK_NS     = 5;
  localparam int          TENTH_CYC  = TENTH_NS / CLK_NS;
  typedef enum logic [2:0] {
    SPL_PM_OFF, SPL_PM_MANUAL, SPL_PM_AUTO, SPL_PM_DI, SPL_PM_DO
  } spl_mode_type;
  typedef enum logic [2:0] {
    SPL_VAL_NONE, SPL_VAL_V10, SPL_VAL_V11, SPL_VAL_BKRS, SPL_VAL_RS
  } spl_val_type;
  typedef enum logic [1:0] {
    SPL_SW_DIRECT, SPL_SW_16, SPL_SW_32, SPL_SW_ALL
  } spl_swap_type;
  typedef enum logic [1:0] {
    SPL_FL_ZERO_VALID, SPL_FL_HOLD, SPL_FL_ZERO_INVALID
  } spl_fail_type;
endpackage

/* hdl/spl_swap.sv */
// byte swap of the mapped process data area
`timescale 1ns/1ps
module spl_swap #(
  parameter int BYTES = 8
) (
  input  wire logic [BYTES*8-1:0] din,
  input  wire logic [1:0]         mode,
  input  wire logic [3:0]         map_len,
  input  wire logic [3:0]         pd_len,
  output logic      [BYTES*8-1:0] dout
);
  if (BYTES != 8) begin : g_size_chk
    $error("spl_swap supports 8 bytes only");
  end
  logic [7:0] fill [BYTES];
  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      // short device data zero-filled, then swapped as data
      fill[i] = (i < pd_len && i < map_len) ? din[i*8 +: 8] : 8'h00; // [R18]
    end
    dout = '0;
    for (int i = 0; i < BYTES; i++) begin
      if (i < map_len) begin
        case (mode)
          2'd1:    dout[i*8 +: 8] = fill[i ^ 1]; // [R14]
          2'd2:    dout[i*8 +: 8] = (map_len == 4'd2) ? fill[i] : fill[i ^ 3]; // [R15] [R17]
          2'd3:    dout[i*8 +: 8] = fill[map_len - 1 - i]; // [R16]
          default: dout[i*8 +: 8] = fill[i]; // [R14]
        endcase
      end
    end
  end
endmodule

/* hdl/spl_top.sv */
// per-channel parameter logic of a sensor port with apb registers
// Summary of operation
// [R1] no check: no compare, no backup
// [R2] validation only in manual start-up
// [R3] storage only manual with v1.1 backup modes
// [R4] backup copies device set, restore writes back
// [R5] 16-bit maker code, default 0x0001
// [R6] 24-bit part code, default 0x000001
// [R7] supply switch, class b only, default off
// [R8] period 0 uses device minimum
// [R9] at or below minimum runs at minimum
// [R10] low six multiplier, top two base
// [R11] base 00 tenths, 1..3 give 0.4
// [R12] base 01 is 6.4 plus 0.4 steps
// [R13] base 10 1.6 steps, top saturates
// [R14] direct passes, 16-bit swaps pairs
// [R15] 32-bit reverses each word
// [R16] whole-area reverses entire area
// [R17] two-byte area ignores 32-bit swap
// [R18] short data zero-filled, swapped too
// [R19] fault zero-valid: zero outputs, valid high
// [R20] fault hold: last value, valid high
// [R21] fault zero-invalid: zero, valid low
// [R22] identity mismatch blocks normal exchange
// [R23] leaving manual forces no check
// [R24] identity change clears backup
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module spl_top #(
  parameter bit CLASS_B = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_fault,
  output logic             supply_on,
  output logic      [63:0] pd_out,
  output logic             pd_out_valid,
  output logic             exchange_en,
  output logic             cycle_tick,
  output logic      [63:0] pd_in_mapped
);
  logic [2:0]  mode_ff;
  logic [2:0]  val_ff;
  logic [1:0]  swap_ff;
  logic [1:0]  fail_ff;
  logic        sup_ff;
  logic [3:0]  map_ff;
  logic [3:0]  pdlen_ff;
  logic [15:0] maker_code_param_ff;
  logic [23:0] part_code_param_ff;
  logic [7:0]  port_period_param_ff;
  logic [15:0] dev_maker_ff;
  logic [23:0] dev_part_ff;
  logic [11:0] dev_min_ff;
  logic [63:0] param_backup_store_ff;
  logic        store_has_ff;
  logic [63:0] dev_param_ff;
  logic [63:0] host_out_ff;
  logic [63:0] dev_in_ff;
  logic        f_s1_ff;
  logic        fault_ff;
  logic        restore_ff;
  logic        id_ok_ff;
  logic [11:0] period_ff;
  logic [31:0] tenth_cnt_ff;
  logic [11:0] tick_cnt_ff;
  logic [31:0] nxt_prdata;
  logic [63:0] swapped;
  logic        wr;
  logic        rd;
  logic        manual;
  logic        cmp_en;
  logic        ds_en;
  logic        id_wr;
  logic        backup_go;
  logic        restore_go;
  logic [11:0] req_tenths;
  logic [11:0] eff_tenths;

  assign wr     = psel && penable && pwrite;
  assign rd     = psel && !penable && !pwrite;
  assign manual = (mode_ff == 3'(spl_pkg::SPL_PM_MANUAL));
  // compare active only in manual mode and a checking setting
  assign cmp_en = manual && (val_ff != 3'(spl_pkg::SPL_VAL_NONE)); // [R1] [R2]
  assign ds_en  = manual && (val_ff == 3'(spl_pkg::SPL_VAL_BKRS) ||
                             val_ff == 3'(spl_pkg::SPL_VAL_RS)); // [R3]

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // apb answers at once: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > spl_pkg::ADDR_CTRL || paddr[1:0] != 2'b00);
      if (rd) begin
        prdata <= nxt_prdata;
      end
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      spl_pkg::ADDR_PORT_CFG: begin
        nxt_prdata[spl_pkg::PM_LSB +: 3]    = mode_ff;
        nxt_prdata[spl_pkg::VAL_LSB +: 3]   = val_ff;
        nxt_prdata[spl_pkg::SWAP_LSB +: 2]  = swap_ff;
        nxt_prdata[spl_pkg::FAIL_LSB +: 2]  = fail_ff;
        nxt_prdata[spl_pkg::SUP_BIT]        = sup_ff;
        nxt_prdata[spl_pkg::MAP_LSB +: 4]   = map_ff;
        nxt_prdata[spl_pkg::PDLEN_LSB +: 4] = pdlen_ff;
      end
      spl_pkg::ADDR_MAKER:  nxt_prdata[15:0] = maker_code_param_ff;
      spl_pkg::ADDR_PART:   nxt_prdata[23:0] = part_code_param_ff;
      spl_pkg::ADDR_PERIOD: nxt_prdata = {4'h0, eff_tenths, 8'h00, port_period_param_ff};
      spl_pkg::ADDR_STATUS: nxt_prdata = {26'h0, fault_ff, id_ok_ff, store_has_ff,
                                          ds_en, cmp_en, exchange_en};
      spl_pkg::ADDR_DEV_ID: nxt_prdata = {dev_part_ff[15:0], dev_maker_ff};
      spl_pkg::ADDR_DEV_MIN: nxt_prdata = {20'h0, dev_min_ff};
      spl_pkg::ADDR_BACKUP: nxt_prdata = param_backup_store_ff[31:0];
      spl_pkg::ADDR_OUT_LO: nxt_prdata = dev_param_ff[31:0];
      spl_pkg::ADDR_OUT_HI: nxt_prdata = dev_param_ff[63:32];
      spl_pkg::ADDR_IN_LO:  nxt_prdata = pd_in_mapped[31:0];
      spl_pkg::ADDR_IN_HI:  nxt_prdata = pd_in_mapped[63:32];
      default:              nxt_prdata = 32'h0000_0000;
    endcase
  end

  // port configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff  <= 3'(spl_pkg::SPL_PM_OFF);
      val_ff   <= 3'(spl_pkg::SPL_VAL_NONE);
      swap_ff  <= 2'(spl_pkg::SPL_SW_DIRECT);
      fail_ff  <= 2'(spl_pkg::SPL_FL_ZERO_INVALID);
      sup_ff   <= 1'b0;
      map_ff   <= spl_pkg::LEN_RST;
      pdlen_ff <= spl_pkg::LEN_RST;
    end else if (wr && paddr == spl_pkg::ADDR_PORT_CFG) begin
      mode_ff  <= pwdata[spl_pkg::PM_LSB +: 3];
      swap_ff  <= pwdata[spl_pkg::SWAP_LSB +: 2];
      fail_ff  <= pwdata[spl_pkg::FAIL_LSB +: 2];
      sup_ff   <= CLASS_B && pwdata[spl_pkg::SUP_BIT]; // [R7]
      map_ff   <= pwdata[spl_pkg::MAP_LSB +: 4];
      pdlen_ff <= pwdata[spl_pkg::PDLEN_LSB +: 4];
      if (pwdata[spl_pkg::PM_LSB +: 3] != 3'(spl_pkg::SPL_PM_MANUAL)) begin
        val_ff <= 3'(spl_pkg::SPL_VAL_NONE); // [R23]
      end else begin
        val_ff <= pwdata[spl_pkg::VAL_LSB +: 3];
      end
    end
  end

  assign id_wr = wr && (paddr == spl_pkg::ADDR_MAKER || paddr == spl_pkg::ADDR_PART);

  // expected identity codes, zero refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maker_code_param_ff  <= spl_pkg::MAKER_RST; // [R5]
      part_code_param_ff   <= spl_pkg::PART_RST; // [R6]
      port_period_param_ff <= spl_pkg::PERIOD_RST;
      dev_maker_ff         <= 16'h0000;
      dev_part_ff          <= 24'h000000;
      dev_min_ff           <= spl_pkg::MIN_TENTHS;
      host_out_ff          <= 64'h0;
      dev_in_ff            <= 64'h0;
      dev_param_ff         <= 64'h0;
    end else if (wr) begin
      case (paddr)
        spl_pkg::ADDR_MAKER: begin
          if (pwdata[15:0] != 16'h0000) maker_code_param_ff <= pwdata[15:0]; // [R5]
        end
        spl_pkg::ADDR_PART: begin
          if (pwdata[23:0] != 24'h0) part_code_param_ff <= pwdata[23:0]; // [R6]
        end
        spl_pkg::ADDR_PERIOD: port_period_param_ff <= pwdata[7:0];
        spl_pkg::ADDR_DEV_ID: begin
          dev_maker_ff <= pwdata[15:0];
          dev_part_ff  <= {8'h00, pwdata[31:16]};
        end
        spl_pkg::ADDR_DEV_MIN: dev_min_ff <= pwdata[11:0];
        spl_pkg::ADDR_OUT_LO: host_out_ff[31:0] <= merge(host_out_ff[31:0], pwdata, pstrb);
        spl_pkg::ADDR_OUT_HI: host_out_ff[63:32] <= merge(host_out_ff[63:32], pwdata, pstrb);
        spl_pkg::ADDR_IN_LO: dev_in_ff[31:0] <= pwdata;
        spl_pkg::ADDR_IN_HI: dev_in_ff[63:32] <= pwdata;
        spl_pkg::ADDR_BACKUP: dev_param_ff <= {dev_param_ff[31:0], pwdata};
        default: ;
      endcase
    end
  end

  // ctrl: bit0 backup request, bit1 restore request
  assign backup_go  = wr && paddr == spl_pkg::ADDR_CTRL && pwdata[0] && ds_en &&
                      val_ff == 3'(spl_pkg::SPL_VAL_BKRS);
  assign restore_go = wr && paddr == spl_pkg::ADDR_CTRL && pwdata[1] && ds_en && store_has_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_backup_store_ff <= 64'h0;
      store_has_ff          <= 1'b0;
      restore_ff            <= 1'b0;
    end else begin
      restore_ff <= restore_go; // [R4]
      if (!ds_en || id_wr) begin
        param_backup_store_ff <= 64'h0; // [R1] [R24]
        store_has_ff          <= 1'b0;
      end else if (backup_go) begin
        param_backup_store_ff <= dev_param_ff; // [R4]
        store_has_ff          <= 1'b1;
      end
    end
  end

  // identity compare gates exchange
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_ok_ff    <= 1'b0;
      exchange_en <= 1'b0;
    end else begin
      id_ok_ff    <= dev_maker_ff == maker_code_param_ff && dev_part_ff == part_code_param_ff;
      exchange_en <= (mode_ff == 3'(spl_pkg::SPL_PM_AUTO)) ||
                     (manual && (!cmp_en || id_ok_ff)); // [R22]
    end
  end

  // cycle-time decode in tenths of ms
  always_comb begin
    case (port_period_param_ff[7:6]) // [R10]
      2'b00: req_tenths = {6'h00, port_period_param_ff[5:0]}; // [R11]
      2'b01: req_tenths = spl_pkg::BASE1_OFS + {4'h0, port_period_param_ff[5:0], 2'b00}; // [R12]
      2'b10: req_tenths = spl_pkg::BASE2_OFS + {2'h0, port_period_param_ff[5:0], 4'h0}; // [R13]
      default: req_tenths = spl_pkg::MAX_TENTHS; // [R13]
    endcase
    if (req_tenths < spl_pkg::MIN_TENTHS) req_tenths = spl_pkg::MIN_TENTHS; // [R11]
    if (port_period_param_ff == 8'h00 || req_tenths <= dev_min_ff) begin
      eff_tenths = dev_min_ff; // [R8] [R9]
    end else begin
      eff_tenths = req_tenths;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ff    <= spl_pkg::MIN_TENTHS;
      tenth_cnt_ff <= 32'h0;
      tick_cnt_ff  <= 12'h000;
      cycle_tick   <= 1'b0;
    end else begin
      period_ff  <= eff_tenths;
      cycle_tick <= 1'b0;
      if (tenth_cnt_ff == 32'(spl_pkg::TENTH_CYC - 1)) begin
        tenth_cnt_ff <= 32'h0;
        if (tick_cnt_ff + 12'h001 >= period_ff) begin
          tick_cnt_ff <= 12'h000;
          cycle_tick  <= exchange_en; // [R9]
        end else begin
          tick_cnt_ff <= tick_cnt_ff + 12'h001;
        end
      end else begin
        tenth_cnt_ff <= tenth_cnt_ff + 32'h1;
      end
    end
  end

  // fault input is asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_s1_ff  <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      f_s1_ff  <= bus_fault;
      fault_ff <= f_s1_ff;
    end
  end

  // output side toward the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_out       <= 64'h0;
      pd_out_valid <= 1'b0;
      supply_on    <= 1'b0;
    end else begin
      supply_on <= sup_ff; // [R7]
      if (restore_ff) begin
        pd_out       <= param_backup_store_ff; // [R4]
        pd_out_valid <= 1'b0;
      end else if (!exchange_en) begin
        pd_out       <= 64'h0;
        pd_out_valid <= 1'b0;
      end else if (!fault_ff) begin
        pd_out       <= host_out_ff;
        pd_out_valid <= 1'b1;
      end else begin
        case (fail_ff)
          2'(spl_pkg::SPL_FL_ZERO_VALID): begin
            pd_out       <= 64'h0; // [R19]
            pd_out_valid <= 1'b1;
          end
          2'(spl_pkg::SPL_FL_HOLD): pd_out_valid <= 1'b1; // [R20]
          default: begin
            pd_out       <= 64'h0; // [R21]
            pd_out_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  spl_swap #(
    .BYTES (8)
  ) u_swap (
    .din     (dev_in_ff),
    .mode    (swap_ff),
    .map_len (map_ff),
    .pd_len  (pdlen_ff),
    .dout    (swapped)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_in_mapped <= 64'h0;
    end else begin
      pd_in_mapped <= swapped; // [R14]
    end
  end

  fault_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    exchange_en && fault_ff && !restore_ff && fail_ff == 2'd0 |=> pd_out == 64'h0 && pd_out_valid)
    else $error("zero-valid fault output wrong"); // [R19]
  fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    exchange_en && fault_ff && !restore_ff && fail_ff == 2'd1 |=> $stable(pd_out) && pd_out_valid)
    else $error("hold fault output wrong"); // [R20]
  fault_inval_a: assert property (@(posedge pclk) disable iff (!presetn)
    exchange_en && fault_ff && !restore_ff && fail_ff == 2'd2 |=> pd_out == 64'h0 && !pd_out_valid)
    else $error("zero-invalid fault output wrong"); // [R21]
  mode_val_a: assert property (@(posedge pclk) disable iff (!presetn)
    !manual |-> val_ff == 3'd0)
    else $error("validation kept outside manual"); // [R23]
  id_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    id_wr |=> !store_has_ff)
    else $error("backup kept after id change"); // [R24]
  ds_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    store_has_ff |-> ds_en || $past(ds_en))
    else $error("storage outside backup modes"); // [R3]
  maker_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    maker_code_param_ff != 16'h0000 && part_code_param_ff != 24'h0)
    else $error("identity code zero"); // [R5]
  period_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    eff_tenths >= dev_min_ff && eff_tenths <= spl_pkg::MAX_TENTHS + dev_min_ff)
    else $error("period below minimum"); // [R9]
endmodule

/* verification/spl_dev_model.sv */
// behavioural field device at the far side of the port
`timescale 1ns/1ps
module spl_dev_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [63:0] pd_out,
  input  wire logic        pd_out_valid,
  output logic      [15:0] dev_maker,
  output logic      [23:0] dev_part,
  output logic      [31:0] dev_param,
  output logic      [63:0] dev_last
);
  // identity values are arbitrary
  assign dev_maker = 16'h3c5a;
  assign dev_part  = 24'h00a7e1;
  assign dev_param = 32'hc3a55a3c;
  // device keeps its last good output once valid drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_last <= 64'h0;
    end else if (pd_out_valid) begin
      dev_last <= pd_out;
    end
  end
endmodule

/* verification/spl_top_tb.sv */
// self-checking testbench of the sensor port parameter logic
`timescale 1ns/1ps
module spl_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, bus_fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dev_param;
  logic [3:0]  pstrb;
  logic        pready, pslverr, supply_on, pd_out_valid, exchange_en, cycle_tick;
  logic [63:0] pd_out, pd_in_mapped, dev_last;
  logic [15:0] dev_maker;
  logic [23:0] dev_part;
  int          miscompares, compares;

  spl_top #(.CLASS_B(1'b1)) spl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_fault(bus_fault),
    .supply_on(supply_on), .pd_out(pd_out), .pd_out_valid(pd_out_valid),
    .exchange_en(exchange_en), .cycle_tick(cycle_tick), .pd_in_mapped(pd_in_mapped));
  spl_dev_model spl_dev_model_i (.pclk(pclk), .presetn(presetn), .pd_out(pd_out),
    .pd_out_valid(pd_out_valid), .dev_maker(dev_maker), .dev_part(dev_part),
    .dev_param(dev_param), .dev_last(dev_last));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_sim;
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      chk("pready", 64'h1, 64'h0);
      end_sim();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, {32'h0, exp}, {32'h0, r & m});
  endtask

  function automatic logic [63:0] probe(input int s);
    case (s)
      0: probe = pd_out;
      1: probe = {63'h0, pd_out_valid};
      2: probe = pd_in_mapped;
      3: probe = {63'h0, supply_on};
      4: probe = {63'h0, exchange_en};
      5: probe = {48'h0, pd_in_mapped[15:0]};
      default: probe = pd_out_valid === 1'b0 ? pd_out : 64'h0;
    endcase
  endfunction

  task automatic expect_port(input string name, input int s, input logic [63:0] exp);
    int n;
    n = 0;
    while (probe(s) !== exp && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(name, exp, probe(s));
    if (n >= 40) begin
      end_sim();
    end
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] pm, input logic [2:0] vl,
    input logic [1:0] sw, input logic [1:0] fl, input logic sp, input logic [3:0] ml,
    input logic [3:0] pl);
    cfg = (32'(pm) << spl_pkg::PM_LSB) | (32'(vl) << spl_pkg::VAL_LSB)
        | (32'(sw) << spl_pkg::SWAP_LSB) | (32'(fl) << spl_pkg::FAIL_LSB)
        | (32'(sp) << spl_pkg::SUP_BIT) | (32'(ml) << spl_pkg::MAP_LSB)
        | (32'(pl) << spl_pkg::PDLEN_LSB);
  endfunction

  task automatic t_reset;
    rd_chk("maker", spl_pkg::ADDR_MAKER, 32'hffff, 32'h0001);
    rd_chk("part", spl_pkg::ADDR_PART, 32'hffffff, 32'h000001);
    rd_chk("port_cfg", spl_pkg::ADDR_PORT_CFG, 32'hffffffff, 32'h08802000);
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h6, 32'h0);
    expect_port("supply_on", 3, 64'h0);
  endtask

  task automatic t_ids;
    logic [31:0] r;
    logic        e;
    wr(spl_pkg::ADDR_MAKER, 32'h0);
    rd_chk("maker", spl_pkg::ADDR_MAKER, 32'hffff, 32'h0001);
    wr(spl_pkg::ADDR_MAKER, 32'hffff);
    rd_chk("maker", spl_pkg::ADDR_MAKER, 32'hffff, 32'hffff);
    wr(spl_pkg::ADDR_PART, 32'h0);
    rd_chk("part", spl_pkg::ADDR_PART, 32'hffffff, 32'h000001);
    wr(spl_pkg::ADDR_PART, 32'hffffff);
    rd_chk("part", spl_pkg::ADDR_PART, 32'hffffff, 32'hffffff);
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk("pslverr", 64'h1, {63'h0, e});
  endtask

  task automatic t_period;
    logic [11:0] mins [10] = '{12'h004, 12'h004, 12'h004, 12'h004, 12'h004, 12'h004,
                               12'h004, 12'h004, 12'h00a, 12'h00a};
    logic [7:0]  vals [10] = '{8'h00, 8'h02, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hbf, 8'hff,
                               8'h05, 8'h00};
    logic [11:0] exps [10] = '{12'h004, 12'h004, 12'h03f, 12'h040, 12'h13c, 12'h140,
                               12'h530, 12'h530, 12'h00a, 12'h00a};
    logic [31:0] x;
    for (int i = 0; i < 10; i++) begin
      wr(spl_pkg::ADDR_DEV_MIN, {20'h0, mins[i]});
      wr(spl_pkg::ADDR_PERIOD, {24'h0, vals[i]});
      x = {4'h0, exps[i], 16'h0};
      rd_chk("period", spl_pkg::ADDR_PERIOD, 32'h0fff0000, x);
    end
  endtask

  task automatic t_swap;
    logic [63:0] exps [4] = '{64'hefcdab8967452301, 64'hcdef89ab45670123,
                              64'h89abcdef01234567, 64'h0123456789abcdef};
    wr(spl_pkg::ADDR_IN_LO, 32'h67452301);
    wr(spl_pkg::ADDR_IN_HI, 32'hefcdab89);
    for (int m = 0; m < 4; m++) begin
      wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h0, 2'(m), 2'h0, 1'b0, 4'h8, 4'h8));
      expect_port("pd_in_mapped", 2, exps[m]);
    end
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h0, 2'h2, 2'h0, 1'b0, 4'h2, 4'h2));
    expect_port("pd_in_mapped", 5, 64'h2301);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h0, 2'h3, 2'h0, 1'b0, 4'h8, 4'h5));
    expect_port("pd_in_mapped", 2, 64'h0123456789000000);
  endtask

  task automatic t_fault;
    logic [63:0] old;
    old = 64'h5566778811223344;
    for (int f = 0; f < 3; f++) begin
      wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h0, 2'h0, 2'(f), 1'b0, 4'h8, 4'h8));
      wr(spl_pkg::ADDR_OUT_LO, 32'h11223344);
      wr(spl_pkg::ADDR_OUT_HI, 32'h55667788);
      expect_port("pd_out", 0, old);
      bus_fault <= 1'b1;
      wr(spl_pkg::ADDR_OUT_LO, 32'h99aabbcc);
      rd_chk("status", spl_pkg::ADDR_STATUS, 32'h20, 32'h20);
      expect_port("pd_out", 0, f == 1 ? old : 64'h0);
      expect_port("pd_out_valid", 1, f == 2 ? 64'h0 : 64'h1);
      @(posedge pclk);
      chk("dev_last", f == 0 ? 64'h0 : old, dev_last);
      bus_fault <= 1'b0;
      expect_port("pd_out", 0, 64'h5566778899aabbcc);
    end
  endtask

  task automatic t_valid;
    logic [31:0] good;
    good = {dev_part[15:0], dev_maker};
    wr(spl_pkg::ADDR_MAKER, {16'h0, dev_maker});
    wr(spl_pkg::ADDR_PART, {8'h0, dev_part});
    wr(spl_pkg::ADDR_DEV_ID, good ^ 32'h1);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_MANUAL, 3'h0, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h3, 32'h1);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_MANUAL, 3'h2, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h13, 32'h02);
    expect_port("exchange_en", 4, 64'h0);
    wr(spl_pkg::ADDR_DEV_ID, good);
    expect_port("exchange_en", 4, 64'h1);
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h13, 32'h13);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h2, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    rd_chk("port_cfg", spl_pkg::ADDR_PORT_CFG, 32'h70, 32'h0);
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h2, 32'h0);
  endtask

  task automatic t_store;
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_MANUAL, 3'h3, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    wr(spl_pkg::ADDR_BACKUP, dev_param);
    wr(spl_pkg::ADDR_BACKUP, dev_param);
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'hc, 32'h4);
    wr(spl_pkg::ADDR_CTRL, 32'h1);
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'hc, 32'hc);
    rd_chk("backup", spl_pkg::ADDR_BACKUP, 32'hffffffff, dev_param);
    wr(spl_pkg::ADDR_CTRL, 32'h2);
    expect_port("restore", 6, {dev_param, dev_param});
    wr(spl_pkg::ADDR_MAKER, {16'h0, dev_maker});
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h8, 32'h0);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_MANUAL, 3'h4, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    wr(spl_pkg::ADDR_CTRL, 32'h1);
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'hc, 32'h4);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_MANUAL, 3'h2, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    rd_chk("status", spl_pkg::ADDR_STATUS, 32'h4, 32'h0);
  endtask

  task automatic t_supply;
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h0, 2'h0, 2'h0, 1'b1, 4'h8, 4'h8));
    expect_port("supply_on", 3, 64'h1);
    wr(spl_pkg::ADDR_PORT_CFG, cfg(spl_pkg::SPL_PM_AUTO, 3'h0, 2'h0, 2'h0, 1'b0, 4'h8, 4'h8));
    expect_port("supply_on", 3, 64'h0);
  endtask

  // auto period with a one-tenth device minimum: tick spacing is one tenth
  task automatic t_tick;
    int n;
    wr(spl_pkg::ADDR_DEV_MIN, 32'h1);
    wr(spl_pkg::ADDR_PERIOD, 32'h0);
    n = 0;
    while (cycle_tick !== 1'b1 && n < 20010) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    n = 1;
    while (cycle_tick !== 1'b1 && n < 20010) begin
      @(posedge pclk);
      n++;
    end
    chk("cycle_tick", 64'(spl_pkg::TENTH_CYC), 64'(n));
    if (n >= 20010) begin
      end_sim();
    end
  endtask

  initial begin
    miscompares = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    bus_fault = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ids();
    t_period();
    t_swap();
    t_fault();
    t_valid();
    t_store();
    t_supply();
    t_tick();
    end_sim();
  end
endmodule
